// file: core/agr_general_regs.sv
// general register bank: control, status, jtag programming, reference count
`timescale 1ns/1ps
module agr_general_regs
    import agr_pkg::*;
#(
    // arbitrary values, replace per build
    parameter logic [7:0] FIRMWARE_REVISION = 8'h01,
    parameter logic [7:0] BOARD_TYPE_CODE = 8'h5a,
    // shorten in simulation; documented period is 2^21 reference ticks
    parameter int PERIOD_LOG2 = AGR_PERIOD_LOG2
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [3:0] reg_addr,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [31:0] reg_wdata,
    output logic [31:0] reg_rdata,
    output logic reg_rvalid,
    output logic eeprom_program_enable,
    output logic eeprom_protect_enable,
    output logic soft_reset,
    output logic local_irq,
    input wire logic hw_led_green,
    input wire logic hw_led_red,
    output logic led_green,
    output logic led_red,
    output logic jtag_reset_n,
    output logic jtag_tms,
    output logic jtag_tck,
    output logic jtag_tdi,
    input wire logic jtag_tdo,
    output logic [31:0] packet_timestamp,
    output logic carrier_tick
);
    // ------------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic program_en;
        logic protect_en;
        logic periodic_irq_enable;
        logic led_override;
        logic led_green_state;
        logic led_red_state;
        logic periodic_irq_pending;
        logic soft_reset;
        logic irq;
        logic led_green;
        logic led_red;
        logic jtag_reset_n;
        logic jtag_tms;
        logic jtag_tck;
        logic jtag_tdi;
        logic [31:0] timestamp;
        logic carrier_tick;
        logic [31:0] rdata;
        logic rvalid;
    } agr_regs_t;

    agr_regs_t st;
    agr_regs_t next_st;

    // ------------------------------------------------------------------------
    // submodules
    // ------------------------------------------------------------------------
    agr_ref_if ref_bus ();

    agr_ref_timer #(
        .PERIOD_LOG2(PERIOD_LOG2)
    ) u_timer (
        .clk(clk),
        .rst(rst),
        .ref_bus(ref_bus.timer)
    );

    logic tdo_level;

    agr_pin_sync #(
        .RESET_LEVEL(1'b0)
    ) u_tdo_sync (
        .clk(clk),
        .rst(rst),
        .pin(jtag_tdo),
        .level(tdo_level)
    );

    // ------------------------------------------------------------------------
    // register views
    // ------------------------------------------------------------------------
    logic [31:0] control_word;
    logic [31:0] status_word;
    logic [31:0] programming_word;

    always_comb begin
        control_word = AGR_RESET_WORD;
        control_word[AGR_CTL_PROGRAM] = st.program_en;
        control_word[AGR_CTL_PROTECT] = st.protect_en;
        // the soft reset bit is write-only and always reads 0
        control_word[AGR_CTL_PERIODIC_EN] = st.periodic_irq_enable;
        control_word[AGR_CTL_FW_LSB +: 8] = FIRMWARE_REVISION;
        control_word[AGR_CTL_TYPE_LSB +: 8] = BOARD_TYPE_CODE;
        control_word[AGR_CTL_LED_OVERRIDE] = st.led_override;
        control_word[AGR_CTL_LED_GREEN] = st.led_green_state;
        control_word[AGR_CTL_LED_RED] = st.led_red_state;
    end

    always_comb begin
        status_word = AGR_RESET_WORD;
        status_word[AGR_STA_PERIODIC] = st.periodic_irq_pending;
    end

    always_comb begin
        programming_word = AGR_RESET_WORD;
        programming_word[AGR_PRG_RESET] = st.jtag_reset_n;
        programming_word[AGR_PRG_TDO] = tdo_level;
        programming_word[AGR_PRG_TMS] = st.jtag_tms;
        programming_word[AGR_PRG_TCK] = st.jtag_tck;
        programming_word[AGR_PRG_TDI] = st.jtag_tdi;
        programming_word[AGR_PRG_PERIODIC] = st.periodic_irq_pending;
    end

    // ------------------------------------------------------------------------
    // write decode
    // ------------------------------------------------------------------------
    logic wr_control;
    logic wr_status;
    logic wr_programming;

    always_comb begin
        wr_control = reg_write && (reg_addr == AGR_OFF_GENERAL_CONTROL);
        wr_status = reg_write && (reg_addr == AGR_OFF_GENERAL_STATUS);
        wr_programming = reg_write && (reg_addr == AGR_OFF_JTAG_PROGRAMMING);
    end

    // ------------------------------------------------------------------------
    // read select
    // ------------------------------------------------------------------------
    logic [31:0] read_word;

    // unmapped offsets read zero so a probing driver sees an empty slot
    always_comb begin
        case (reg_addr)
            AGR_OFF_GENERAL_CONTROL: begin
                read_word = control_word;
            end
            AGR_OFF_GENERAL_STATUS: begin
                read_word = status_word;
            end
            AGR_OFF_JTAG_PROGRAMMING: begin
                read_word = programming_word;
            end
            AGR_OFF_REFERENCE_CLOCK_COUNT: begin
                // live count, not the delayed stamp copy
                read_word = ref_bus.ref_count;
            end
            default: begin
                read_word = AGR_RESET_WORD;
            end
        endcase
    end

    // ------------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------------
    always_comb begin
        next_st = st;
        next_st.soft_reset = 1'b0;
        next_st.rvalid = 1'b0;

        // ------------------------------------------------------------------
        // general control write
        // ------------------------------------------------------------------
        if (wr_control) begin
            next_st.program_en = reg_wdata[AGR_CTL_PROGRAM];
            next_st.protect_en = reg_wdata[AGR_CTL_PROTECT];
            next_st.periodic_irq_enable = reg_wdata[AGR_CTL_PERIODIC_EN];
            next_st.led_override = reg_wdata[AGR_CTL_LED_OVERRIDE];
            next_st.led_green_state = reg_wdata[AGR_CTL_LED_GREEN];
            next_st.led_red_state = reg_wdata[AGR_CTL_LED_RED];
            // every write of 1 fires again, nothing to clear first
            next_st.soft_reset = reg_wdata[AGR_CTL_SOFT_RESET];
        end

        // ------------------------------------------------------------------
        // soft reset
        // ------------------------------------------------------------------
        // the pulse goes to the channels, which idle their control fields,
        // flush fifo stages, zero load counts and clear their status flags;
        // eeprom bits and enables stay as they are; here the led override is dropped
        if (next_st.soft_reset) begin
            next_st.led_override = 1'b0;
        end

        // ------------------------------------------------------------------
        // jtag lines
        // ------------------------------------------------------------------
        // bit-level only: software paces the clock, so no shifter is needed
        if (wr_programming) begin
            next_st.jtag_reset_n = reg_wdata[AGR_PRG_RESET];
            next_st.jtag_tms = reg_wdata[AGR_PRG_TMS];
            next_st.jtag_tck = reg_wdata[AGR_PRG_TCK];
            next_st.jtag_tdi = reg_wdata[AGR_PRG_TDI];
        end

        // ------------------------------------------------------------------
        // periodic interrupt
        // ------------------------------------------------------------------
        // write-one-to-clear, but a tick in the same cycle wins
        if (wr_status && reg_wdata[AGR_STA_PERIODIC]) begin
            next_st.periodic_irq_pending = 1'b0;
        end
        if (ref_bus.period_tick) begin
            next_st.periodic_irq_pending = 1'b1;
        end

        next_st.irq = next_st.periodic_irq_pending && next_st.periodic_irq_enable;

        // ------------------------------------------------------------------
        // led drive
        // ------------------------------------------------------------------
        // leds follow receive hardware unless software has taken over
        if (next_st.led_override) begin
            next_st.led_green = next_st.led_green_state;
            next_st.led_red = next_st.led_red_state;
        end else begin
            next_st.led_green = hw_led_green;
            next_st.led_red = hw_led_red;
        end

        // ------------------------------------------------------------------
        // reference timing to the channels
        // ------------------------------------------------------------------
        next_st.timestamp = ref_bus.ref_count;
        next_st.carrier_tick = ref_bus.carrier_tick;

        // ------------------------------------------------------------------
        // read port: one cycle latency, unmapped reads return zero
        // ------------------------------------------------------------------
        // rdata holds between reads so a slow host can still pick it up
        if (reg_read) begin
            next_st.rvalid = 1'b1;
            next_st.rdata = read_word;
        end
    end

    // ------------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // ------------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------------
    assign reg_rdata = st.rdata;
    assign reg_rvalid = st.rvalid;
    assign eeprom_program_enable = st.program_en;
    assign eeprom_protect_enable = st.protect_en;
    assign soft_reset = st.soft_reset;
    assign local_irq = st.irq;
    assign led_green = st.led_green;
    assign led_red = st.led_red;
    assign jtag_reset_n = st.jtag_reset_n;
    assign jtag_tms = st.jtag_tms;
    assign jtag_tck = st.jtag_tck;
    assign jtag_tdi = st.jtag_tdi;
    assign packet_timestamp = st.timestamp;
    assign carrier_tick = st.carrier_tick;
endmodule

// file: core/agr_pkg.sv
// shared constants for the general register bank
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
package agr_pkg;
    localparam logic [3:0] AGR_OFF_GENERAL_CONTROL = 4'h0;
    localparam logic [3:0] AGR_OFF_GENERAL_STATUS = 4'h4;
    localparam logic [3:0] AGR_OFF_JTAG_PROGRAMMING = 4'h8;
    localparam logic [3:0] AGR_OFF_REFERENCE_CLOCK_COUNT = 4'hc;
    // general control fields
    localparam int AGR_CTL_PROGRAM = 0;
    localparam int AGR_CTL_PROTECT = 1;
    localparam int AGR_CTL_SOFT_RESET = 2;
    localparam int AGR_CTL_PERIODIC_EN = 4;
    localparam int AGR_CTL_FW_LSB = 8;
    localparam int AGR_CTL_TYPE_LSB = 16;
    localparam int AGR_CTL_LED_OVERRIDE = 24;
    localparam int AGR_CTL_LED_GREEN = 25;
    localparam int AGR_CTL_LED_RED = 26;
    // general status and programming fields
    localparam int AGR_STA_PERIODIC = 4;
    localparam int AGR_PRG_RESET = 0;
    localparam int AGR_PRG_TDO = 1;
    localparam int AGR_PRG_TMS = 2;
    localparam int AGR_PRG_TCK = 3;
    localparam int AGR_PRG_TDI = 4;
    localparam int AGR_PRG_PERIODIC = 5;
    // reference tick generation: 40.5 MHz ticks from the 125 MHz clock
    localparam int AGR_CLK_FREQ_KHZ = 125000;
    localparam int AGR_REF_FREQ_KHZ = 40500;
    localparam int AGR_ACC_W = 18;
    localparam logic [AGR_ACC_W-1:0] AGR_ACC_MOD = AGR_ACC_W'(AGR_CLK_FREQ_KHZ);
    localparam logic [AGR_ACC_W-1:0] AGR_ACC_INC = AGR_ACC_W'(AGR_REF_FREQ_KHZ);
    localparam int AGR_PERIOD_LOG2 = 21;
    // divide by 1.5: two carrier ticks out of every three reference ticks
    localparam logic [1:0] AGR_CARRIER_PHASES = 2'h2;
    localparam logic [31:0] AGR_RESET_WORD = 32'h0000_0000;
endpackage

// file: core/agr_ref_if.sv
// reference timing signals between the timer and the register bank
`timescale 1ns/1ps
interface agr_ref_if;
    logic [31:0] ref_count;
    logic ref_tick;
    logic period_tick;
    logic carrier_tick;
    modport timer (
        output ref_count,
        output ref_tick,
        output period_tick,
        output carrier_tick
    );
    modport user (
        input ref_count,
        input ref_tick,
        input period_tick,
        input carrier_tick
    );
endinterface

// file: core/agr_pin_sync.sv
// three-stage synchroniser for pin inputs, accepts a level once the second and third stages agree
`timescale 1ns/1ps
module agr_pin_sync
    import agr_pkg::*;
#(
    parameter logic RESET_LEVEL = 1'b0
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic pin,
    output logic level
);
    typedef struct packed {
        logic s1;
        logic s2;
        logic s3;
        logic q;
    } agr_sync_t;

    agr_sync_t st;
    agr_sync_t next_st;

    always_comb begin
        next_st = st;
        next_st.s1 = pin;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        if (st.s2 == st.s3) begin
            next_st.q = st.s3;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st <= {4{RESET_LEVEL}};
        end else begin
            st <= next_st;
        end
    end

    assign level = st.q;
endmodule

// file: core/agr_ref_timer.sv
// reference tick generator, free-running reference counter, carrier divider
`timescale 1ns/1ps
module agr_ref_timer
    import agr_pkg::*;
#(
    parameter int PERIOD_LOG2 = AGR_PERIOD_LOG2
) (
    input wire logic clk,
    input wire logic rst,
    agr_ref_if.timer ref_bus
);
    typedef struct packed {
        logic [AGR_ACC_W-1:0] acc;
        logic [31:0] count;
        logic [1:0] phase;
        logic ref_tick;
        logic period_tick;
        logic carrier_tick;
    } agr_timer_t;

    agr_timer_t st;
    agr_timer_t next_st;
    logic [AGR_ACC_W-1:0] sum;

    // fractional accumulator: average tick rate is exactly 40.5/125 of clk
    always_comb begin
        next_st = st;
        sum = st.acc + AGR_ACC_INC;
        next_st.ref_tick = 1'b0;
        next_st.period_tick = 1'b0;
        next_st.carrier_tick = 1'b0;
        if (sum >= AGR_ACC_MOD) begin
            next_st.acc = sum - AGR_ACC_MOD;
            next_st.ref_tick = 1'b1;
            next_st.count = st.count + 32'h0000_0001;
            next_st.period_tick = (next_st.count[PERIOD_LOG2-1:0] == '0);
            next_st.carrier_tick = (st.phase != AGR_CARRIER_PHASES);
            next_st.phase = (st.phase == AGR_CARRIER_PHASES) ? 2'h0 : st.phase + 2'h1;
        end else begin
            next_st.acc = sum;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign ref_bus.ref_count = st.count;
    assign ref_bus.ref_tick = st.ref_tick;
    assign ref_bus.period_tick = st.period_tick;
    assign ref_bus.carrier_tick = st.carrier_tick;
endmodule

// file: test/agr_general_regs_checker.sv
// concurrent checks on the ports of the general register bank
`timescale 1ns/1ps
module agr_general_regs_checker
    import agr_pkg::*;
#(
    parameter logic [7:0] FIRMWARE_REVISION = 8'h01,
    parameter logic [7:0] BOARD_TYPE_CODE = 8'h5a
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [3:0] reg_addr,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [31:0] reg_wdata,
    input wire logic [31:0] reg_rdata,
    input wire logic reg_rvalid,
    input wire logic eeprom_program_enable,
    input wire logic eeprom_protect_enable,
    input wire logic soft_reset,
    input wire logic hw_led_green,
    input wire logic hw_led_red,
    input wire logic led_green,
    input wire logic led_red,
    input wire logic jtag_reset_n,
    input wire logic jtag_tms,
    input wire logic jtag_tck,
    input wire logic jtag_tdi,
    input wire logic [31:0] packet_timestamp,
    input wire logic carrier_tick
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_wr(logic [3:0] a);
        reg_write && reg_addr == a;
    endsequence
    sequence s_rd(logic [3:0] a);
        reg_read && reg_addr == a;
    endsequence
    a_fixed_fields: assert property (s_rd(AGR_OFF_GENERAL_CONTROL) |=> reg_rdata[31:27] == 5'h0
        && reg_rdata[23:8] == {BOARD_TYPE_CODE, FIRMWARE_REVISION}) else $error("control fixed fields wrong");
    a_status_zero: assert property (s_rd(AGR_OFF_GENERAL_STATUS) |=> (reg_rdata & 32'hffffffef) == 32'h0)
        else $error("status reserved bits set");
    a_prog_zero: assert property (s_rd(AGR_OFF_JTAG_PROGRAMMING) |=> reg_rdata[31:6] == 26'h0)
        else $error("programming upper bits set");
    a_eeprom_pins: assert property (s_wr(AGR_OFF_GENERAL_CONTROL) |=>
        {eeprom_protect_enable, eeprom_program_enable} == $past(reg_wdata[1:0])) else $error("eeprom pins wrong");
    a_soft_pulse: assert property (s_wr(AGR_OFF_GENERAL_CONTROL) ##0 reg_wdata[2] |=> soft_reset)
        else $error("soft reset missing");
    a_soft_cause: assert property (soft_reset |-> $past(reg_write && reg_addr == 4'h0 && reg_wdata[2]))
        else $error("spurious soft reset");
    a_led_after_soft: assert property (soft_reset |=> {led_red, led_green} == $past({hw_led_red, hw_led_green}))
        else $error("led not back to hardware");
    a_jtag_pins: assert property (s_wr(AGR_OFF_JTAG_PROGRAMMING) |=>
        {jtag_tdi, jtag_tck, jtag_tms, jtag_reset_n} == $past({reg_wdata[4:2], reg_wdata[0]})) else $error("jtag pins wrong");
    a_stamp_step: assert property (packet_timestamp - $past(packet_timestamp) <= 32'h1)
        else $error("time stamp step wrong");
    a_carrier_gap: assert property (carrier_tick |=> !carrier_tick [*2])
        else $error("carrier ticks too close");
    a_read_valid: assert property (reg_rvalid == $past(reg_read))
        else $error("read valid not one cycle after read");
endmodule
bind agr_general_regs agr_general_regs_checker #(.FIRMWARE_REVISION(FIRMWARE_REVISION),
    .BOARD_TYPE_CODE(BOARD_TYPE_CODE)) chk_u (.clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_write(reg_write),
    .reg_read(reg_read), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .eeprom_program_enable(eeprom_program_enable), .eeprom_protect_enable(eeprom_protect_enable),
    .soft_reset(soft_reset), .hw_led_green(hw_led_green), .hw_led_red(hw_led_red), .led_green(led_green),
    .led_red(led_red), .jtag_reset_n(jtag_reset_n), .jtag_tms(jtag_tms), .jtag_tck(jtag_tck),
    .jtag_tdi(jtag_tdi), .packet_timestamp(packet_timestamp), .carrier_tick(carrier_tick));

// file: test/agr_host_model.sv
// host side model: drives the register strobes of the bank
`timescale 1ns/1ps
module agr_host_model (
    input wire logic clk,
    output logic [3:0] reg_addr,
    output logic reg_write,
    output logic reg_read,
    output logic [31:0] reg_wdata,
    input wire logic [31:0] reg_rdata
);
    initial begin
        reg_addr = 4'h0;
        reg_write = 1'b0;
        reg_read = 1'b0;
        reg_wdata = 32'h0;
    end
    // data is inverted after the strobe so a stale word is never mistaken for fresh
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk);
        reg_write <= 1'b0;
        reg_wdata <= ~d;
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        #1;
        d = reg_rdata;
    endtask
endmodule

// file: test/agr_general_regs_tb_top.sv
// self-checking bench for the general register bank
`timescale 1ns/1ps
module agr_general_regs_tb_top;
    localparam logic [7:0] FW = 8'h01;
    // arbitrary board code
    localparam logic [7:0] BT = 8'h5a;
    logic clk, rst, hw_led_green, hw_led_red, jtag_tdo;
    logic [3:0] reg_addr;
    logic reg_write, reg_read, soft_reset, local_irq, carrier_tick;
    logic led_green, led_red, eeprom_program_enable, eeprom_protect_enable;
    logic jtag_reset_n, jtag_tms, jtag_tck, jtag_tdi;
    logic [31:0] reg_wdata, reg_rdata, packet_timestamp, d, a;
    int failures = 0;
    int compares = 0;
    int pulses = 0;
    int carriers = 0;
    int c0;
    time t1;
    agr_general_regs #(.FIRMWARE_REVISION(FW), .BOARD_TYPE_CODE(BT), .PERIOD_LOG2(4)) dut_u (.clk(clk), .rst(rst),
        .reg_addr(reg_addr), .reg_write(reg_write), .reg_read(reg_read), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_rvalid(), .eeprom_program_enable(eeprom_program_enable),
        .eeprom_protect_enable(eeprom_protect_enable), .soft_reset(soft_reset), .local_irq(local_irq),
        .hw_led_green(hw_led_green), .hw_led_red(hw_led_red), .led_green(led_green), .led_red(led_red),
        .jtag_reset_n(jtag_reset_n), .jtag_tms(jtag_tms), .jtag_tck(jtag_tck), .jtag_tdi(jtag_tdi),
        .jtag_tdo(jtag_tdo), .packet_timestamp(packet_timestamp), .carrier_tick(carrier_tick));
    agr_host_model h_u (.clk(clk), .reg_addr(reg_addr), .reg_write(reg_write), .reg_read(reg_read),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        pulses <= pulses + int'(soft_reset);
        carriers <= carriers + int'(carrier_tick);
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wait_irq();
        for (int n = 0; n < 200 && local_irq !== 1'b1; n++) begin
            @(posedge clk);
            #1;
        end
    endtask
    task automatic test_done();
        $display("compares=%0d failures=%0d", compares, failures);
        if (failures == 0 && compares > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    // ----
    // main sequence
    // ----
    initial begin
        {rst, hw_led_green, hw_led_red, jtag_tdo} = 4'b1010;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        h_u.wr(4'h4, 32'h10);
        h_u.rd(4'h0, d);
        chk(d, {8'h0, BT, FW, 8'h0});
        h_u.rd(4'h4, d);
        chk(d, 32'h0);
        h_u.wr(4'h0, 32'hfbfff0fb);
        @(posedge clk);
        #1;
        h_u.rd(4'h0, d);
        chk(d, {8'h03, BT, FW, 8'h13});
        chk({eeprom_protect_enable, eeprom_program_enable, led_red, led_green}, 4'b1101);
        h_u.wr(4'h0, 32'h01000017);
        h_u.wr(4'h0, 32'h01000017);
        @(posedge clk);
        #1;
        chk(pulses, 2);
        chk({led_red, led_green}, 2'b10);
        h_u.rd(4'h0, d);
        chk(d, {8'h00, BT, FW, 8'h13});
        // periodic interrupt: rise to rise spacing is 16 ticks, about 49 clocks
        // clear first so the timing base is a real rising edge
        h_u.wr(4'h4, 32'h10);
        wait_irq();
        t1 = $time;
        chk(local_irq, 1'b1);
        h_u.rd(4'h4, d);
        chk(d, 32'h10);
        h_u.rd(4'h8, d);
        chk(d[5], 1'b1);
        h_u.wr(4'h4, 32'h10);
        #1;
        chk(local_irq, 1'b0);
        wait_irq();
        chk(($time - t1) >= 384 && ($time - t1) <= 408, 1'b1);
        h_u.wr(4'h0, 32'h0);
        h_u.wr(4'h4, 32'h10);
        repeat (60) @(posedge clk);
        #1;
        chk(local_irq, 1'b0);
        h_u.rd(4'h4, d);
        chk(d, 32'h10);
        // jtag lines both ways
        h_u.wr(4'h8, 32'hffffffff);
        jtag_tdo <= 1'b1;
        repeat (6) @(posedge clk);
        h_u.rd(4'h8, d);
        chk(d & 32'hffffffdf, 32'h1f);
        chk({jtag_tdi, jtag_tck, jtag_tms, jtag_reset_n}, 4'hf);
        h_u.wr(4'h8, 32'h0);
        jtag_tdo <= 1'b0;
        repeat (6) @(posedge clk);
        h_u.rd(4'h8, d);
        chk(d & 32'hffffffdf, 32'h0);
        // reference count rate, carrier at two thirds of it, count not writable
        h_u.rd(4'hc, a);
        c0 = carriers;
        h_u.wr(4'hc, 32'h0);
        repeat (98) @(posedge clk);
        h_u.rd(4'hc, d);
        chk((d - a) >= 32 && (d - a) <= 34, 1'b1);
        chk((carriers - c0) >= 20 && (carriers - c0) <= 23, 1'b1);
        h_u.wr(4'h3, 32'hffffffff);
        h_u.rd(4'h3, d);
        chk(d, 32'h0);
        // hardware reset drops the led takeover
        h_u.wr(4'h0, 32'h03000000);
        @(posedge clk);
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        h_u.rd(4'h0, d);
        chk(d, {8'h0, BT, FW, 8'h0});
        chk({led_red, led_green}, 2'b10);
        test_done();
    end
    initial begin
        repeat (5000) @(posedge clk);
        failures++;
        test_done();
    end
endmodule
